// *** core/srs_reset_sequencer.sv ***
// system reset sequencer: cause gathering, boot sequence, cause flags and apb registers
// Notes on behaviour
// [R01] reset on power, watchdog, brown-out, enabled pin
// [R02] while resetting hold core, clear program counter
// [R03] after sequence, execute from address zero
// [R04] cause code in flag bits 7:6
// [R05] order: supply wait, pin, init, warm-up, run
// [R06] enabled pin low keeps device in reset
// [R07] watchdog overflow resets the device
// [R08] watchdog reset: init, warm-up, then run
// [R09] warm-up length follows oscillator type
// [R10] brown-out threshold is the detector level
// [R11] detector reset clears both low-supply flags
// [R12] cause loaded once per reset, then kept
`timescale 1ns/1ns
`default_nettype none
module srs_reset_sequencer
    import srs_pkg::*;
#(
    parameter int unsigned PWR_STABLE = PWR_STABLE_CYC,
    parameter int unsigned RC_WARM = RC_WARM_CYC,
    parameter int unsigned XTAL_WARM = XTAL_WARM_CYC
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_ok_raw,
    input wire logic brownout_raw,
    input wire logic ext_reset_pin_n,
    input wire logic low_mid_raw,
    input wire logic low_high_raw,
    input wire logic wdt_overflow,
    output logic core_reset_n,
    output logic pc_clear,
    output logic irq
);
    // two-flop synchronisers for all asynchronous pin-side inputs
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    srs_pins_t pins;
    // sequencer state, counter and control
    srs_state_t state_reg;
    srs_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [1:0] ctrl_reg;
    logic [1:0] cause_reg;      // cause visible to software
    logic [1:0] pend_reg;       // cause of the reset in progress
    logic [1:0] low_reg;        // low-supply flags {high, mid}
    logic [2:0] alu_reg;        // carry, half carry, zero storage
    logic [EVT_W-1:0] evt_reg;
    logic [EVT_W-1:0] mask_reg;
    logic [EVT_W-1:0] evt_set;
    // decoded causes
    logic pin_en;
    logic pin_low;
    logic wdt_hit;
    logic warm_done;
    logic [CNT_W-1:0] warm_len;
    // apb decode
    logic [9:0] idx;
    logic mapped;
    logic wr_en;
    logic flags_wr;

    // first flop feeds only the second flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
        end
        else
        begin
            sync1_reg <= {low_high_raw, low_mid_raw, ext_reset_pin_n, brownout_raw, supply_ok_raw};
            sync2_reg <= sync1_reg;
        end
    end
    assign pins = srs_pins_t'(sync2_reg);

    // cause decode; brown-out threshold is whatever the detector reports
    assign pin_en = ctrl_reg[CTRL_PIN_EN_BIT];
    assign pin_low = pin_en && !pins.pin_n;                                // [R06]
    assign wdt_hit = (state_reg == ST_RUN) && wdt_overflow;                // [R07]
    // crystal needs a long warm-up, rc a short one
    assign warm_len = ctrl_reg[CTRL_XTAL_BIT] ? CNT_W'(XTAL_WARM) : CNT_W'(RC_WARM); // [R09]
    assign warm_done = (cnt_reg >= warm_len - CNT_W'(1));

    // next state: brown-out beats pin, pin beats watchdog
    // the pin is only looked at once the supply wait is over, so a low pin cannot skip it
    always_comb
    begin
        state_next = state_reg;
        if (pins.brownout)                                                 // [R01] [R10]
            state_next = ST_PWR_WAIT;
        else if (pin_low && state_reg != ST_PWR_WAIT)                      // [R01] [R06]
            state_next = ST_PIN_CHECK;
        else if (wdt_hit)                                                  // [R07] [R08]
            state_next = ST_INIT;
        else
        begin
            unique case (state_reg)
                ST_PWR_WAIT:
                begin
                    // supply must stay good for the whole settle time
                    if (pins.supply_ok && cnt_reg >= CNT_W'(PWR_STABLE - 1))
                        state_next = ST_PIN_CHECK;                         // [R05]
                end
                ST_PIN_CHECK: state_next = ST_INIT;                        // [R05]
                ST_INIT: state_next = ST_WARM;                             // [R05] [R08]
                ST_WARM:
                    if (warm_done)
                        state_next = ST_RUN;                               // [R03]
                ST_RUN: state_next = ST_RUN;
            endcase
        end
    end

    // state register; power-on starts in the supply wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= ST_PWR_WAIT;
        else
            state_reg <= state_next;
    end

    // cycle counter restarts on every state change and, in the supply wait, while supply is bad
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= '0;
        else if (state_next != state_reg || (state_reg == ST_PWR_WAIT && !pins.supply_ok))
            cnt_reg <= '0;
        else if (state_reg != ST_RUN)
            cnt_reg <= cnt_reg + CNT_W'(1);
    end

    // core held and program counter cleared outside run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_reset_n <= 1'b0;
            pc_clear <= 1'b1;
        end
        else
        begin
            core_reset_n <= (state_next == ST_RUN);                        // [R02] [R03]
            pc_clear <= (state_next != ST_RUN);                            // [R02]
        end
    end

    // pending cause: latest event wins, power code after power-on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_reg <= CAUSE_POWER;
        else if (pins.brownout)
            pend_reg <= CAUSE_POWER;                                       // [R04]
        else if (pin_low)
            pend_reg <= CAUSE_PIN;                                         // [R04]
        else if (wdt_hit)
            pend_reg <= CAUSE_WDT;                                         // [R04]
    end

    // apb decode; answer in the first access cycle
    assign idx = paddr[11:2];
    assign mapped = (idx == FLAGS_IDX) || (idx == CTRL_IDX) || (idx == EVT_IDX) || (idx == MASK_IDX);
    assign wr_en = psel && penable && pready && pwrite && mapped;
    assign flags_wr = wr_en && (idx == FLAGS_IDX);

    // cause field: loaded once in init, else only software changes it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cause_reg <= CAUSE_POWER;
        else if (state_reg == ST_INIT)
            cause_reg <= pend_reg;                                         // [R04] [R12]
        else if (flags_wr)
            cause_reg <= pwdata[CAUSE_HI_BIT:CAUSE_LO_BIT];                // [R12]
    end

    // low-supply flags follow the supply, cleared by a detector reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_reg <= 2'h0;
        else if (pins.brownout || (state_reg == ST_PWR_WAIT && pend_reg == CAUSE_POWER))
            low_reg <= 2'h0;                                               // [R11]
        else
            low_reg <= {pins.low_high, pins.low_mid};
    end

    // arithmetic flags held at initial value while not running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alu_reg <= 3'h0;
        else if (state_reg != ST_RUN)
            alu_reg <= 3'h0;                                               // [R02]
        else if (flags_wr)
            alu_reg <= pwdata[2:0];
    end

    // control: pin enable and oscillator type
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= CTRL_RST;
        else if (wr_en && idx == CTRL_IDX)
            ctrl_reg <= pwdata[1:0];
    end

    // event sources; a set in the clearing cycle is kept
    always_comb
    begin
        evt_set = '0;
        evt_set[EVT_WDT] = wdt_hit;
        evt_set[EVT_BROWN] = pins.brownout && state_reg == ST_RUN;
        evt_set[EVT_PIN] = pin_low && state_reg == ST_RUN;
        evt_set[EVT_DONE] = (state_reg == ST_WARM) && (state_next == ST_RUN);
    end

    // sticky events, write one to clear, and the mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_reg <= '0;
            mask_reg <= '0;
        end
        else
        begin
            if (wr_en && idx == EVT_IDX)
            begin
                evt_reg <= (evt_reg & ~pwdata[EVT_W-1:0]) | evt_set;
            end
            else
            begin
                evt_reg <= evt_reg | evt_set;
            end
            if (wr_en && idx == MASK_IDX)
            begin
                mask_reg <= pwdata[EVT_W-1:0];
            end
        end
    end

    // level interrupt from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(((evt_reg | evt_set) & mask_reg));
        end
    end

    // apb answer: ready, data and error loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= '0;
            if (psel && !penable && !pwrite)
            begin
                // unmapped reads return zero; bit 3 reads zero
                unique case (idx)
                    FLAGS_IDX: prdata <= {24'h0, cause_reg, low_reg, 1'b0, alu_reg};
                    CTRL_IDX: prdata <= {30'h0, ctrl_reg};
                    EVT_IDX: prdata <= {28'h0, evt_reg};
                    MASK_IDX: prdata <= {28'h0, mask_reg};
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // checks
    sequence s_warm_exit;
        state_reg == ST_WARM && warm_done && !pins.brownout && !pin_low;
    endsequence
    sequence s_run_start;
        state_reg == ST_RUN ##0 core_reset_n;
    endsequence

    property p_brownout_hold;
        @(posedge pclk) disable iff (!presetn) pins.brownout |=> state_reg == ST_PWR_WAIT && !core_reset_n;
    endproperty
    a_brownout_hold: assert property (p_brownout_hold) else $error("brown-out did not restart sequence"); // [R01]

    property p_core_held;
        @(posedge pclk) disable iff (!presetn) state_reg != ST_RUN |-> !core_reset_n && pc_clear;
    endproperty
    a_core_held: assert property (p_core_held) else $error("core released outside run"); // [R02]

    property p_run_start;
        @(posedge pclk) disable iff (!presetn) s_warm_exit |=> s_run_start;
    endproperty
    a_run_start: assert property (p_run_start) else $error("execution did not start after warm-up"); // [R03]

    property p_wdt_cause;
        @(posedge pclk) disable iff (!presetn)
            wdt_hit && !pins.brownout && !pin_low |=> state_reg == ST_INIT ##1 cause_reg == CAUSE_WDT;
    endproperty
    a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog cause not recorded"); // [R04]

    property p_pin_hold;
        @(posedge pclk) disable iff (!presetn)
            pin_low && !pins.brownout && state_reg != ST_PWR_WAIT |=> state_reg == ST_PIN_CHECK;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin low did not hold reset"); // [R06]

    property p_order;
        @(posedge pclk) disable iff (!presetn)
            state_reg == ST_PIN_CHECK && !pin_low && !pins.brownout |=> state_reg == ST_INIT ##1 state_reg == ST_WARM;
    endproperty
    a_order: assert property (p_order) else $error("sequence order broken"); // [R05]

    property p_wdt_restart;
        @(posedge pclk) disable iff (!presetn)
            wdt_hit && !pins.brownout && !pin_low |=> !core_reset_n ##1 state_reg == ST_WARM;
    endproperty
    a_wdt_restart: assert property (p_wdt_restart) else $error("watchdog restart wrong"); // [R07] [R08]

    property p_xtal_warm;
        @(posedge pclk) disable iff (!presetn)
            state_reg == ST_INIT && ctrl_reg[CTRL_XTAL_BIT] && XTAL_WARM > 8 && !pins.brownout && !pin_low
            |=> (state_reg == ST_WARM || pins.brownout || pin_low) [*8];
    endproperty
    a_xtal_warm: assert property (p_xtal_warm) else $error("crystal warm-up too short"); // [R09]

    property p_flags_clear;
        @(posedge pclk) disable iff (!presetn) pins.brownout |=> low_reg == 2'h0;
    endproperty
    a_flags_clear: assert property (p_flags_clear) else $error("low-supply flags not cleared"); // [R11]

    property p_cause_kept;
        @(posedge pclk) disable iff (!presetn) state_reg == ST_RUN && !flags_wr |=> $stable(cause_reg);
    endproperty
    a_cause_kept: assert property (p_cause_kept) else $error("cause changed while running"); // [R12]

endmodule // srs_reset_sequencer
`default_nettype wire

// *** core/srs_pkg.sv ***
// package: constants and types of the system reset sequencer
package srs_pkg;
    // clock rate and timing (times in ns, counts derived, least times round up)
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned PWR_STABLE_NS = 10000;
    localparam int unsigned RC_WARM_NS = 2000;
    localparam int unsigned XTAL_WARM_NS = 100000;
    localparam int unsigned PWR_STABLE_CYC = (PWR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RC_WARM_CYC = (RC_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned XTAL_WARM_CYC = (XTAL_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 12;
    // register indices; byte address is four times the index
    localparam logic [9:0] FLAGS_IDX = 10'h086;
    localparam logic [9:0] CTRL_IDX = 10'h088;
    localparam logic [9:0] EVT_IDX = 10'h089;
    localparam logic [9:0] MASK_IDX = 10'h08a;
    // program_flags field positions
    localparam int unsigned CAUSE_HI_BIT = 7;
    localparam int unsigned CAUSE_LO_BIT = 6;
    localparam int unsigned LOW_HIGH_BIT = 5;
    localparam int unsigned LOW_MID_BIT = 4;
    // control register fields and reset value
    localparam int unsigned CTRL_PIN_EN_BIT = 0;
    localparam int unsigned CTRL_XTAL_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    // reset cause codes in program_flags[7:6]
    localparam logic [1:0] CAUSE_WDT = 2'h0;
    localparam logic [1:0] CAUSE_RSVD = 2'h1;
    localparam logic [1:0] CAUSE_POWER = 2'h2;
    localparam logic [1:0] CAUSE_PIN = 2'h3;
    // event status bit positions
    localparam int unsigned EVT_WDT = 0;
    localparam int unsigned EVT_BROWN = 1;
    localparam int unsigned EVT_PIN = 2;
    localparam int unsigned EVT_DONE = 3;
    localparam int unsigned EVT_W = 4;
    // synchroniser reset value: pin idles high, everything else low
    localparam logic [4:0] SYNC_RST = 5'h04;
    // sequencer states
    typedef enum logic [2:0] {ST_PWR_WAIT, ST_PIN_CHECK, ST_INIT, ST_WARM, ST_RUN} srs_state_t;
    // synchronised pin-side inputs travel together
    typedef struct packed {
        logic low_high;   // supply below upper flag level
        logic low_mid;    // supply below middle flag level
        logic pin_n;      // external reset pin level
        logic brownout;   // detector below reset level
        logic supply_ok;  // supply reported stable
    } srs_pins_t;
endpackage

// *** test/srs_supply_model.sv ***
// supply monitor and external reset pin driver that stand outside the sequencer
`timescale 1ns/1ns
`default_nettype none
module srs_supply_model
    import srs_pkg::*;
#(
    parameter int DET_MV = 2000,
    parameter int MID_MV = 2400,
    parameter int HIGH_MV = 3600
)(
    input wire logic pclk,
    output logic supply_ok,
    output logic brownout,
    output logic pin_n,
    output logic low_mid,
    output logic low_high
);
    srs_pins_t pins; // detector and pin levels kept together inside the model
    int level_mv = 0; // supply level in millivolts, starts unpowered

    // each level leaves on its own wire, as on the real pins
    assign supply_ok = pins.supply_ok;
    assign brownout = pins.brownout;
    assign pin_n = pins.pin_n;
    assign low_mid = pins.low_mid;
    assign low_high = pins.low_high;
    logic pin_level = 1'b1; // pin idles high, pulled up when nobody drives it low

    // power off at time zero: detector low, pin high
    initial
    begin
        pins = 5'h1e;
    end

    // detector outputs follow the level, changed just after an edge
    always @(posedge pclk)
    begin
        pins.brownout <= (level_mv < DET_MV);
        pins.supply_ok <= (level_mv >= DET_MV);
        pins.low_mid <= (level_mv <= MID_MV);
        pins.low_high <= (level_mv <= HIGH_MV);
        pins.pin_n <= pin_level;
    end

    // move the supply to a new level
    task automatic set_level(input int mv);
    begin
        level_mv <= mv;
    end
    endtask

    // pull the pin low for a while, then let it back high so the sequence can go on
    task automatic hold_pin(input int cyc);
    begin
        pin_level <= 1'b0;
        repeat (cyc) @(posedge pclk);
        pin_level <= 1'b1;
    end
    endtask
endmodule // srs_supply_model
`default_nettype wire

// *** test/test_system_reset_sequencer.sv ***
// self-checking bench for the system reset sequencer
`timescale 1ns/1ns
`default_nettype none
module test_system_reset_sequencer
    import srs_pkg::*;
;
    localparam int RCW = 2; // short rc warm-up keeps the run brief
    localparam int XW = 12; // crystal warm-up, longer than rc
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic wdt_overflow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_reset_n;
    logic pc_clear;
    logic irq;
    logic supply_ok; // supply monitor and pin levels from the far-side model
    logic brownout;
    logic pin_n;
    logic low_mid;
    logic low_high;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [32:0] note_q[$]; // expected {pslverr, prdata} per transfer
    logic [32:0] note;

    srs_reset_sequencer #(.PWR_STABLE(4), .RC_WARM(RCW), .XTAL_WARM(XW)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_ok_raw(supply_ok), .brownout_raw(brownout), .ext_reset_pin_n(pin_n),
        .low_mid_raw(low_mid), .low_high_raw(low_high), .wdt_overflow(wdt_overflow),
        .core_reset_n(core_reset_n), .pc_clear(pc_clear), .irq(irq));

    srs_supply_model model_u (
        .pclk(pclk),
        .supply_ok(supply_ok),
        .brownout(brownout),
        .pin_n(pin_n),
        .low_mid(low_mid),
        .low_high(low_high)
    );

    // 25 mhz clock
    initial
    begin
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    // one apb transfer; the answer is judged by the monitor below
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd, input logic [32:0] exp);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        note_q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    begin
        apb(1'b0, idx, 32'h0, {1'b0, exp});
    end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    begin
        apb(1'b1, idx, d, 33'h0);
    end
    endtask

    // wait for the core to leave reset, bounded; cyc is the time spent
    task automatic wait_run(output int cyc);
    begin
        cyc = 0;
        while (core_reset_n !== 1'b1 && cyc < 400)
        begin
            @(posedge pclk);
            cyc++;
        end
        chk("core_reset_n", 32'h1, 32'(core_reset_n));
        chk("pc_clear", 32'h0, 32'(pc_clear));
    end
    endtask

    // one-cycle watchdog overflow, then the restart time
    task automatic wdt_kick(output int cyc);
    begin
        @(posedge pclk);
        wdt_overflow <= 1'b1;
        @(posedge pclk);
        wdt_overflow <= 1'b0;
        @(posedge pclk);
        chk("core_reset_n", 32'h0, 32'(core_reset_n));
        chk("pc_clear", 32'h1, 32'(pc_clear));
        wait_run(cyc);
    end
    endtask

    task automatic end_of_test;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    // takes the oldest note whenever an access completes and compares
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            note = note_q.pop_front();
            num_checks++;
            if (pslverr !== note[32] || (!pwrite && prdata !== note[31:0]))
            begin
                n_mismatch++;
                $display("mismatch apb %h expected %h seen %h", paddr, note, {pslverr, prdata});
            end
        end
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #(40 * 20000);
        n_mismatch++;
        end_of_test;
    end

    initial
    begin
        int c_rc;
        int c_x;
        int k;
        logic [31:0] r;
        r = $urandom(5);
        repeat (2) @(posedge pclk);
        chk("core_reset_n", 32'h0, 32'(core_reset_n));
        chk("pc_clear", 32'h1, 32'(pc_clear));
        chk("irq", 32'h0, 32'(irq));
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("core_reset_n", 32'h0, 32'(core_reset_n));
        model_u.set_level(5000);
        wait_run(k);
        rd(FLAGS_IDX, 32'h80);
        rd(CTRL_IDX, 32'h1);
        rd(EVT_IDX, 32'h8);
        rd(MASK_IDX, 32'h0);
        apb(1'b0, 10'h000, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 10'h000, 32'hff, {1'b1, 32'h0});
        $display("test power_up done");
        wr(MASK_IDX, 32'h8);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, 32'(irq));
        wr(EVT_IDX, 32'h8);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, 32'(irq));
        rd(EVT_IDX, 32'h0);
        for (k = 0; k < 3; k++)
        begin
            r = $urandom & 32'hf;
            wr(MASK_IDX, r);
            rd(MASK_IDX, r);
        end
        wr(MASK_IDX, 32'h0);
        $display("test interrupt done");
        wr(FLAGS_IDX, 32'h40);
        rd(FLAGS_IDX, 32'h40);
        model_u.set_level(3000);
        repeat (4) @(posedge pclk);
        rd(FLAGS_IDX, 32'h60);
        model_u.set_level(5000);
        $display("test flags done");
        wdt_kick(c_rc);
        rd(FLAGS_IDX, 32'h0);
        wr(CTRL_IDX, 32'h3);
        wdt_kick(c_x);
        chk("warm span", 32'(XW - RCW), 32'(c_x - c_rc));
        $display("test watchdog done");
        model_u.hold_pin(30);
        chk("core_reset_n", 32'h0, 32'(core_reset_n));
        wait_run(k);
        rd(FLAGS_IDX, 32'hc0);
        wr(CTRL_IDX, 32'h2);
        model_u.hold_pin(20);
        repeat (4) @(posedge pclk);
        chk("core_reset_n", 32'h1, 32'(core_reset_n));
        $display("test pin done");
        model_u.set_level(1900);
        repeat (6) @(posedge pclk);
        chk("core_reset_n", 32'h0, 32'(core_reset_n));
        rd(FLAGS_IDX, 32'hc0);
        model_u.set_level(5000);
        wait_run(k);
        rd(FLAGS_IDX, 32'h80);
        rd(EVT_IDX, 32'hf);
        $display("test brownout done");
        end_of_test;
    end
endmodule // test_system_reset_sequencer
`default_nettype wire
